/* src/pxc_params.svh */
`ifndef PXC_PARAMS_SVH
`define PXC_PARAMS_SVH

// ----------------------------------------------------------------------
// management register addresses and frame fields
// ----------------------------------------------------------------------
`define PXC_MREG_EXT_ADDR 5'h1E
`define PXC_MREG_EXTENDED_DATA_WINDOW 5'h1F
`define PXC_OP_WRITE 2'h1
`define PXC_OP_READ 2'h2
`define PXC_PREAMBLE_BITS 6'h20
`define PXC_PHY_ADDR 5'h00

// ----------------------------------------------------------------------
// extended register addresses and reset values
// ----------------------------------------------------------------------
`define PXC_XREG_10M_PWR 16'h200A
`define PXC_XREG_COMBO 16'h4000
`define PXC_XREG_PAD 16'h4001
`define PXC_XREG_COMBO2 16'h4003
`define PXC_10M_PWR_RST 16'hCA02
`define PXC_COMBO_RST 16'h0000
`define PXC_PAD_RST 16'h80EF
`define PXC_COMBO2_RST 16'h0260

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PXC_BIT_IDLE_DAC_OFF 10
`define PXC_BIT_REMOTE_LOOP 11
`define PXC_BIT_JUMBO 5
`define PXC_BIT_PAD_SRC 4
`define PXC_BIT_WAKE_EN 2
`define PXC_BIT_RMII_EN 1
`define PXC_BIT_CLK_SEL 0
`define PXC_BIT_IRQ_SEL 15
`define PXC_MAC_DRV_HI 5
`define PXC_MAC_DRV_LO 4
`define PXC_MGMT_DRV_HI 3
`define PXC_MGMT_DRV_LO 2
`define PXC_BIT_DAC_TO_RXC 14
`define PXC_SHAPE_HI 9
`define PXC_SHAPE_LO 7
`define PXC_BIT_ISO_TXC 6
`define PXC_BIT_ISO_RXC 5
`define PXC_SCAN_DRIVE 2'h3

// ----------------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------------
`define PXC_JUMBO_BYTES 15'd18432
`define PXC_STD_BYTES 15'd4608
`define PXC_CLK_PERIOD_NS 8
`define PXC_WAKE_10US_NS 10000
`define PXC_WAKE_100US_NS 100000
`define PXC_WAKE_1MS_NS 1000000
`define PXC_WAKE_10MS_NS 10000000

`endif

/* src/pxc_pkg.sv */
package pxc_pkg;

	typedef enum logic [1:0] {
		mii_mode,
		reverse_media_if_mode,
		reduced_if_variant_two,
		reduced_if_variant_one
	} pxc_if_mode_t;

	typedef enum logic [2:0] {
		st_pre,
		st_start,
		st_op,
		st_phy,
		st_reg,
		st_ta,
		st_data
	} pxc_mdio_st_t;

endpackage : pxc_pkg

/* src/pxc_sync.sv */
`timescale 1ns/10ps

module pxc_sync #(
	parameter int WIDTH = 4
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : pxc_sync

/* src/pxc_wake_irq.sv */
`timescale 1ns/10ps
`include "pxc_params.svh"

module pxc_wake_irq #(
	parameter logic [20:0] W0_CYC = 21'(`PXC_WAKE_10US_NS / `PXC_CLK_PERIOD_NS),
	parameter logic [20:0] W1_CYC = 21'(`PXC_WAKE_100US_NS / `PXC_CLK_PERIOD_NS),
	parameter logic [20:0] W2_CYC = 21'(`PXC_WAKE_1MS_NS / `PXC_CLK_PERIOD_NS),
	parameter logic [20:0] W3_CYC = 21'(`PXC_WAKE_10MS_NS / `PXC_CLK_PERIOD_NS)
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic wake_event,
	input wire logic wake_clear,
	input wire logic [2:0] shape,
	output logic irq
);

	logic level_q;
	logic [20:0] cnt_q;
	logic [20:0] width;
	logic hit;

	assign hit = enable & wake_event;

	always_comb
	begin
		case (shape[2:1])
		2'h0: width = W0_CYC;
		2'h1: width = W1_CYC;
		2'h2: width = W2_CYC;
		default: width = W3_CYC;
		endcase
	end

	// set wins over clear so a wake in the clear cycle survives
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			level_q <= 1'b0;
		else if (hit)
			level_q <= 1'b1;
		else if (wake_clear)
			level_q <= 1'b0;
	end

	// a new wake during a pulse restarts the full width
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (hit && shape[0])
			cnt_q <= width;
		else if (cnt_q != 21'h0)
			cnt_q <= cnt_q - 21'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= shape[0] ? (cnt_q != 21'h0) : level_q;
	end

endmodule : pxc_wake_irq

/* src/pxc_ext_regs.sv */
`timescale 1ns/10ps
`include "pxc_params.svh"

module pxc_ext_regs
	import pxc_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = `PXC_PHY_ADDR,
	parameter logic [20:0] WAKE_100US_CYC = 21'(`PXC_WAKE_100US_NS / `PXC_CLK_PERIOD_NS),
	parameter logic [20:0] WAKE_1MS_CYC = 21'(`PXC_WAKE_1MS_NS / `PXC_CLK_PERIOD_NS),
	parameter logic [20:0] WAKE_10MS_CYC = 21'(`PXC_WAKE_10MS_NS / `PXC_CLK_PERIOD_NS)
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic clk_sel_strap,
	input wire logic rx_data_bit_one_strap,
	input wire logic speed_10m,
	input wire logic tx_data_pending,
	input wire logic link_pulse_pending,
	input wire logic rx_dv,
	input wire logic crs_dv,
	input wire logic [14:0] rx_frame_bytes,
	input wire logic isolate,
	input wire logic scan_mode,
	input wire logic general_irq,
	input wire logic led_status,
	input wire logic wake_event,
	input wire logic wake_clear,
	output logic ten_mbit_idle_dac_off,
	output logic remote_loopback_en,
	output logic [14:0] max_frame_bytes,
	output logic frame_too_long,
	output logic crs_dv_pad,
	output pxc_if_mode_t mac_if_mode,
	output logic clocks_are_inputs,
	output logic txc_oe_n,
	output logic rxc_oe_n,
	output logic rxc_from_dac,
	output logic [1:0] mac_pin_drive_level,
	output logic [1:0] mgmt_pin_drive_level,
	output logic wake_detect_enable,
	output logic wake_irq,
	output logic status_light_zero_pin
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic mdc_s;
	logic mdio_s;
	logic clk_sel_s;
	logic rxd1_s;
	logic mdc_prev_q;
	logic mdc_rise;

	pxc_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({mdc, mdio_in, clk_sel_strap, rx_data_bit_one_strap}),
		.q({mdc_s, mdio_s, clk_sel_s, rxd1_s})
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mdc_prev_q <= 1'b0;
		else
			mdc_prev_q <= mdc_s;
	end

	// mdc is slow against clk, so a sampled rising edge is enough
	assign mdc_rise = mdc_s & ~mdc_prev_q;

	// ------------------------------------------------------------------
	// strap capture after reset release
	// ------------------------------------------------------------------
	logic [1:0] strap_cnt_q;
	logic strap_take;
	logic strap_rxd1_q;

	// the synchroniser needs two edges before its output is the pin
	assign strap_take = (strap_cnt_q == 2'h2);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			strap_cnt_q <= 2'h0;
		else if (strap_cnt_q != 2'h3)
			strap_cnt_q <= strap_cnt_q + 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			strap_rxd1_q <= 1'b0;
		else if (strap_take)
			strap_rxd1_q <= rxd1_s;
	end

	// ------------------------------------------------------------------
	// management frame engine
	// ------------------------------------------------------------------
	pxc_mdio_st_t state_q;
	logic [5:0] cnt_q;
	logic [1:0] op_q;
	logic [4:0] phy_q;
	logic [4:0] reg_q;
	logic [15:0] sh_q;
	logic wr_stb_q;
	logic ours;
	logic claimed;
	logic [15:0] mgmt_rdata;

	assign ours = (phy_q == PHY_ADDR);
	assign claimed = ours && (reg_q == `PXC_MREG_EXT_ADDR || reg_q == `PXC_MREG_EXTENDED_DATA_WINDOW);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= st_pre;
			cnt_q <= 6'h00;
			op_q <= 2'h0;
			phy_q <= 5'h00;
			reg_q <= 5'h00;
			sh_q <= 16'h0000;
			wr_stb_q <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe_n <= 1'b1;
		end
		else
		begin
			wr_stb_q <= 1'b0;
			if (mdc_rise)
			begin
				case (state_q)
				st_pre:
				begin
					if (mdio_s)
					begin
						if (cnt_q != `PXC_PREAMBLE_BITS)
							cnt_q <= cnt_q + 6'h01;
					end
					else if (cnt_q == `PXC_PREAMBLE_BITS)
					begin
						cnt_q <= 6'h00;
						state_q <= st_start;
					end
					else
						cnt_q <= 6'h00;
				end
				st_start:
				begin
					cnt_q <= 6'h00;
					state_q <= mdio_s ? st_op : st_pre;
				end
				st_op:
				begin
					op_q <= {op_q[0], mdio_s};
					cnt_q <= (cnt_q == 6'h01) ? 6'h00 : cnt_q + 6'h01;
					if (cnt_q == 6'h01)
						state_q <= st_phy;
				end
				st_phy:
				begin
					phy_q <= {phy_q[3:0], mdio_s};
					cnt_q <= (cnt_q == 6'h04) ? 6'h00 : cnt_q + 6'h01;
					if (cnt_q == 6'h04)
						state_q <= st_reg;
				end
				st_reg:
				begin
					reg_q <= {reg_q[3:0], mdio_s};
					cnt_q <= (cnt_q == 6'h04) ? 6'h00 : cnt_q + 6'h01;
					if (cnt_q == 6'h04)
						state_q <= st_ta;
				end
				st_ta:
				begin
					if (op_q == `PXC_OP_READ && claimed)
					begin
						// host releases the first turnaround bit, we pull the second low
						mdio_oe_n <= 1'b0;
						mdio_out <= (cnt_q == 6'h00) ? 1'b0 : mgmt_rdata[15];
						if (cnt_q == 6'h01)
							sh_q <= {mgmt_rdata[14:0], 1'b0};
					end
					cnt_q <= (cnt_q == 6'h01) ? 6'h00 : cnt_q + 6'h01;
					if (cnt_q == 6'h01)
						state_q <= st_data;
				end
				st_data:
				begin
					if (op_q == `PXC_OP_READ && claimed)
					begin
						mdio_out <= (cnt_q == 6'h0F) ? 1'b1 : sh_q[15];
						mdio_oe_n <= (cnt_q == 6'h0F);
						sh_q <= {sh_q[14:0], 1'b0};
					end
					else
						sh_q <= {sh_q[14:0], mdio_s};
					if (cnt_q == 6'h0F)
					begin
						wr_stb_q <= (op_q == `PXC_OP_WRITE) && ours;
						cnt_q <= 6'h00;
						state_q <= st_pre;
					end
					else
						cnt_q <= cnt_q + 6'h01;
				end
				default:
				begin
					cnt_q <= 6'h00;
					mdio_oe_n <= 1'b1;
					state_q <= st_pre;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// address and extended registers
	// ------------------------------------------------------------------
	logic [15:0] ext_addr_q;
	logic [15:0] pwr_q;
	logic [15:0] combo_q;
	logic [15:0] pad_q;
	logic [15:0] combo2_q;
	logic [15:0] xreg_rdata;
	logic wr_win;

	assign wr_win = wr_stb_q && (reg_q == `PXC_MREG_EXTENDED_DATA_WINDOW);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ext_addr_q <= 16'h0000;
		else if (wr_stb_q && reg_q == `PXC_MREG_EXT_ADDR)
			ext_addr_q <= sh_q;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_q <= `PXC_10M_PWR_RST;
		else if (wr_win && ext_addr_q == `PXC_XREG_10M_PWR)
			pwr_q <= sh_q;
	end

	// strap load only happens once, right after release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			combo_q <= `PXC_COMBO_RST;
		else if (strap_take)
			combo_q[`PXC_BIT_CLK_SEL] <= clk_sel_s;
		else if (wr_win && ext_addr_q == `PXC_XREG_COMBO)
			combo_q <= sh_q;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pad_q <= `PXC_PAD_RST;
		else if (wr_win && ext_addr_q == `PXC_XREG_PAD)
			pad_q <= sh_q;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			combo2_q <= `PXC_COMBO2_RST;
		else if (wr_win && ext_addr_q == `PXC_XREG_COMBO2)
			combo2_q <= sh_q;
	end

	always_comb
	begin
		case (ext_addr_q)
		`PXC_XREG_10M_PWR: xreg_rdata = pwr_q;
		`PXC_XREG_COMBO: xreg_rdata = combo_q;
		`PXC_XREG_PAD: xreg_rdata = pad_q;
		`PXC_XREG_COMBO2: xreg_rdata = combo2_q;
		default: xreg_rdata = 16'h0000;
		endcase
	end

	assign mgmt_rdata = (reg_q == `PXC_MREG_EXT_ADDR) ? ext_addr_q : xreg_rdata;

	// ------------------------------------------------------------------
	// control decode
	// ------------------------------------------------------------------
	assign remote_loopback_en = combo_q[`PXC_BIT_REMOTE_LOOP];
	assign wake_detect_enable = combo_q[`PXC_BIT_WAKE_EN];
	assign mac_if_mode = pxc_if_mode_t'({combo_q[`PXC_BIT_RMII_EN],
		combo_q[`PXC_BIT_CLK_SEL]});
	assign clocks_are_inputs = combo_q[`PXC_BIT_CLK_SEL];
	assign rxc_from_dac = combo2_q[`PXC_BIT_DAC_TO_RXC];
	assign max_frame_bytes = combo_q[`PXC_BIT_JUMBO] ? `PXC_JUMBO_BYTES : `PXC_STD_BYTES;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ten_mbit_idle_dac_off <= 1'b0;
			frame_too_long <= 1'b0;
			crs_dv_pad <= 1'b0;
		end
		else
		begin
			// dac back on the cycle after work appears, at the cost of one flop of lag
			ten_mbit_idle_dac_off <= pwr_q[`PXC_BIT_IDLE_DAC_OFF] & speed_10m
				& ~tx_data_pending & ~link_pulse_pending;
			frame_too_long <= (rx_frame_bytes > max_frame_bytes);
			if (combo_q[`PXC_BIT_RMII_EN] && combo_q[`PXC_BIT_PAD_SRC])
				crs_dv_pad <= rx_dv;
			else
				crs_dv_pad <= crs_dv;
		end
	end

	// scan mode forces the strongest drive so test timing stays fixed
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mac_pin_drive_level <= `PXC_SCAN_DRIVE;
			mgmt_pin_drive_level <= `PXC_SCAN_DRIVE;
		end
		else if (scan_mode)
		begin
			mac_pin_drive_level <= `PXC_SCAN_DRIVE;
			mgmt_pin_drive_level <= `PXC_SCAN_DRIVE;
		end
		else
		begin
			mac_pin_drive_level <= pad_q[`PXC_MAC_DRV_HI:`PXC_MAC_DRV_LO];
			mgmt_pin_drive_level <= pad_q[`PXC_MGMT_DRV_HI:`PXC_MGMT_DRV_LO];
		end
	end

	// ------------------------------------------------------------------
	// clock pin direction
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txc_oe_n <= 1'b1;
			rxc_oe_n <= 1'b1;
		end
		else if (isolate)
		begin
			// a clear enable holds whatever direction the pin had
			if (combo2_q[`PXC_BIT_ISO_TXC])
				txc_oe_n <= 1'b1;
			if (combo2_q[`PXC_BIT_ISO_RXC])
				rxc_oe_n <= 1'b1;
		end
		else
		begin
			txc_oe_n <= combo_q[`PXC_BIT_CLK_SEL];
			rxc_oe_n <= combo_q[`PXC_BIT_CLK_SEL] & ~combo2_q[`PXC_BIT_DAC_TO_RXC];
		end
	end

	// ------------------------------------------------------------------
	// wake interrupt and light pin
	// ------------------------------------------------------------------
	pxc_wake_irq #(
		.W0_CYC(21'(`PXC_WAKE_10US_NS / `PXC_CLK_PERIOD_NS)),
		.W1_CYC(WAKE_100US_CYC),
		.W2_CYC(WAKE_1MS_CYC),
		.W3_CYC(WAKE_10MS_CYC)
	) u_wake (
		.clk(clk),
		.rst_n(rst_n),
		.enable(combo_q[`PXC_BIT_WAKE_EN]),
		.wake_event(wake_event),
		.wake_clear(wake_clear),
		.shape(combo2_q[`PXC_SHAPE_HI:`PXC_SHAPE_LO]),
		.irq(wake_irq)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status_light_zero_pin <= 1'b0;
		else if (strap_rxd1_q)
			status_light_zero_pin <= pad_q[`PXC_BIT_IRQ_SEL] ? general_irq : wake_irq;
		else
			status_light_zero_pin <= led_status;
	end

endmodule : pxc_ext_regs

/* dv/pxc_mdio_host.sv */
`timescale 1ns/10ps

module pxc_mdio_host (
	output logic mdc,
	output logic host_oe,
	output logic host_out,
	input wire logic mdio
);
	// ----------------------------------------
	// management station, one frame per call
	// ----------------------------------------
	initial
	begin
		mdc = 1'b0;
		host_oe = 1'b0;
		host_out = 1'b1;
	end

	// clock stands low between frames; data changes on the falling edge
	task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, rd ? 2'b11 : 2'b10, wd};
		rdat = 16'h0000;
		for (int i = 63; i >= 0; i--)
		begin
			mdc = 1'b0;
			host_oe = !(rd && i < 18);
			host_out = bits[i];
			#62.5;
			mdc = 1'b1;
			if (i < 16)
				rdat[i] = mdio;
			#62.5;
		end
		mdc = 1'b0;
		host_oe = 1'b0;
	endtask : frame
endmodule : pxc_mdio_host

/* dv/pxc_ext_regs_props.sv */
`timescale 1ns/10ps
`include "pxc_params.svh"

module pxc_ext_regs_chk
	import pxc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	input wire logic speed_10m,
	input wire logic tx_data_pending,
	input wire logic link_pulse_pending,
	input wire logic crs_dv,
	input wire logic [14:0] rx_frame_bytes,
	input wire logic isolate,
	input wire logic wake_event,
	input wire logic ten_mbit_idle_dac_off,
	input wire logic [14:0] max_frame_bytes,
	input wire logic frame_too_long,
	input wire logic crs_dv_pad,
	input wire pxc_if_mode_t mac_if_mode,
	input wire logic txc_oe_n,
	input wire logic rxc_oe_n,
	input wire logic wake_detect_enable,
	input wire logic wake_irq
);
	// ----------------------------------------
	// port relations
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_lim;
		max_frame_bytes == `PXC_JUMBO_BYTES || max_frame_bytes == `PXC_STD_BYTES;
	endproperty
	a_lim: assert property (p_lim) else $error("frame limit off");
	property p_long;
		$past(rst_n) |-> frame_too_long == ($past(rx_frame_bytes) > $past(max_frame_bytes));
	endproperty
	a_long: assert property (p_long) else $error("too long flag");
	property p_pad;
		$past(rst_n) && !$past(mac_if_mode[1]) |-> crs_dv_pad == $past(crs_dv);
	endproperty
	a_pad: assert property (p_pad) else $error("carrier pad source");
	property p_dac;
		ten_mbit_idle_dac_off |-> $past(speed_10m && !tx_data_pending && !link_pulse_pending);
	endproperty
	a_dac: assert property (p_dac) else $error("dac off while busy");
	// keep-previous also forbids a fall while isolated
	property p_txc;
		$past(isolate) && $past(isolate, 2) |-> !$fell(txc_oe_n);
	endproperty
	a_txc: assert property (p_txc) else $error("tx clock driven in isolate");
	property p_rxc;
		$past(isolate) && $past(isolate, 2) |-> !$fell(rxc_oe_n);
	endproperty
	a_rxc: assert property (p_rxc) else $error("rx clock driven in isolate");
	property p_wake;
		$rose(wake_irq) |-> $past(wake_event && wake_detect_enable, 2)
			|| $past(wake_event && wake_detect_enable, 3);
	endproperty
	a_wake: assert property (p_wake) else $error("wake irq without armed event");
	property p_ta;
		$fell(mdio_oe_n) |-> !mdio_out;
	endproperty
	a_ta: assert property (p_ta) else $error("turnaround not zero");
endmodule : pxc_ext_regs_chk

bind pxc_ext_regs pxc_ext_regs_chk u_chk (.clk(clk), .rst_n(rst_n), .mdio_out(mdio_out),
	.mdio_oe_n(mdio_oe_n), .speed_10m(speed_10m), .tx_data_pending(tx_data_pending),
	.link_pulse_pending(link_pulse_pending), .crs_dv(crs_dv), .rx_frame_bytes(rx_frame_bytes),
	.isolate(isolate), .wake_event(wake_event), .ten_mbit_idle_dac_off(ten_mbit_idle_dac_off),
	.max_frame_bytes(max_frame_bytes), .frame_too_long(frame_too_long), .crs_dv_pad(crs_dv_pad),
	.mac_if_mode(mac_if_mode), .txc_oe_n(txc_oe_n), .rxc_oe_n(rxc_oe_n),
	.wake_detect_enable(wake_detect_enable), .wake_irq(wake_irq));

/* dv/tb.sv */
`timescale 1ns/10ps
`include "pxc_params.svh"

module tb;
	import pxc_pkg::*;
	localparam logic [20:0] W1 = 21'h14;
	localparam logic [20:0] W2 = 21'h28;
	localparam logic [20:0] W3 = 21'h50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mdc, host_oe, host_out, mdio, mo, moe;
	logic sp, txp, lpp, rxdv, crsdv, iso, scan, girq, wev, wclr;
	logic dac, lpb, ftl, pad, cin, txoe, rxoe, rdac, wen, wirq, lit;
	logic [14:0] fb, maxf;
	logic [1:0] macdr, mgdr;
	logic [15:0] rv, d;
	pxc_if_mode_t mode;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int k;
	logic [15:0] ra [4] = '{`PXC_XREG_10M_PWR, `PXC_XREG_COMBO, `PXC_XREG_PAD, `PXC_XREG_COMBO2};
	logic [15:0] rs [4] = '{`PXC_10M_PWR_RST, 16'h0001, `PXC_PAD_RST, `PXC_COMBO2_RST};
	logic [20:0] wid [4] = '{21'(`PXC_WAKE_10US_NS / `PXC_CLK_PERIOD_NS), W1, W2, W3};

	// ----------------------------------------
	// clock, wire and instances
	// ----------------------------------------
	always #4 clk = ~clk;
	// management wire has a pull-up
	assign mdio = !moe ? mo : (host_oe ? host_out : 1'b1);

	pxc_mdio_host u_host (.mdc(mdc), .host_oe(host_oe), .host_out(host_out), .mdio(mdio));
	pxc_ext_regs #(.WAKE_100US_CYC(W1), .WAKE_1MS_CYC(W2), .WAKE_10MS_CYC(W3)) u_dut (
		.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio), .mdio_out(mo), .mdio_oe_n(moe),
		.clk_sel_strap(1'b1), .rx_data_bit_one_strap(1'b1), .speed_10m(sp),
		.tx_data_pending(txp), .link_pulse_pending(lpp), .rx_dv(rxdv), .crs_dv(crsdv),
		.rx_frame_bytes(fb), .isolate(iso), .scan_mode(scan), .general_irq(girq),
		.led_status(1'b0), .wake_event(wev), .wake_clear(wclr), .ten_mbit_idle_dac_off(dac),
		.remote_loopback_en(lpb), .max_frame_bytes(maxf), .frame_too_long(ftl),
		.crs_dv_pad(pad), .mac_if_mode(mode), .clocks_are_inputs(cin), .txc_oe_n(txoe),
		.rxc_oe_n(rxoe), .rxc_from_dac(rdac), .mac_pin_drive_level(macdr),
		.mgmt_pin_drive_level(mgdr), .wake_detect_enable(wen), .wake_irq(wirq),
		.status_light_zero_pin(lit));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// ends on a falling edge so outputs are settled
	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask : clks
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		logic [15:0] x;
		u_host.frame(1'b0, 5'h00, a, v, x);
		clks(8);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		u_host.frame(1'b1, 5'h00, a, 16'h0000, v);
	endtask : rd
	task automatic xwr(input logic [15:0] a, input logic [15:0] v);
		wr(`PXC_MREG_EXT_ADDR, a);
		wr(`PXC_MREG_EXTENDED_DATA_WINDOW, v);
	endtask : xwr
	// an output argument would only reach the pin when the task returns
	task automatic pin(input int w, input logic v);
		@(posedge clk);
		case (w)
			0: iso <= v;
			1: wev <= v;
			2: wclr <= v;
			default: scan <= v;
		endcase
		clks(4);
	endtask : pin
	function automatic logic [14:0] lim(input logic j);
		return j ? `PXC_JUMBO_BYTES : `PXC_STD_BYTES;
	endfunction : lim
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			errors++;
			conclude();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{sp, txp, lpp, rxdv, crsdv, iso, scan, girq, wev, wclr} = '0;
		fb = '0;
		void'($urandom(32'h17241583));
		clks(8);
		@(posedge clk);
		rst_n <= 1'b1;
		clks(6);
		rd(`PXC_MREG_EXT_ADDR, rv);
		chk(rv, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			wr(`PXC_MREG_EXT_ADDR, ra[i]);
			rd(`PXC_MREG_EXTENDED_DATA_WINDOW, rv);
			chk(rv, rs[i]);
		end
		chk(16'({macdr, mgdr, mode, lpb, wen}), 16'({2'h2, 2'h3, 2'h1, 2'h0}));
		$display("test reset done");
		for (int n = 0; n < 2; n++)
			for (int i = 0; i < 4; i++)
			begin
				d = 16'($urandom()) | (n ? 16'h0000 : 16'h0412);
				@(posedge clk);
				sp <= 1'b1;
				rxdv <= 1'($urandom());
				crsdv <= 1'($urandom());
				girq <= 1'($urandom());
				fb <= n ? 15'($urandom()) : lim(d[5]);
				xwr(ra[i], d);
				rd(`PXC_MREG_EXTENDED_DATA_WINDOW, rv);
				chk(rv, d);
				case (i)
					0: chk(16'(dac), 16'(d[10]));
					1:
					begin
						chk(16'({lpb, wen, mode, cin}), 16'({d[11], d[2], d[1:0], d[0]}));
						chk(16'(maxf), 16'(lim(d[5])));
						chk(16'(ftl), 16'(fb > lim(d[5])));
						chk(16'(pad), 16'(d[1] && d[4] ? rxdv : crsdv));
					end
					2: chk(16'({macdr, mgdr, lit}), 16'({d[5:4], d[3:2], d[15] & girq}));
					default: chk(16'(rdac), 16'(d[14]));
				endcase
			end
		$display("test random done");
		xwr(16'h1234, 16'hBEEF);
		rd(`PXC_MREG_EXTENDED_DATA_WINDOW, rv);
		chk(rv, 16'h0000);
		u_host.frame(1'b1, 5'h01, `PXC_MREG_EXTENDED_DATA_WINDOW, 16'h0000, rv);
		chk(rv, 16'hFFFF);
		$display("test refuse done");
		xwr(`PXC_XREG_COMBO, 16'h0000);
		xwr(`PXC_XREG_COMBO2, 16'h0060);
		chk(16'({txoe, rxoe}), 16'h0000);
		pin(0, 1'b1);
		chk(16'({txoe, rxoe}), 16'h0003);
		xwr(`PXC_XREG_COMBO2, 16'h0000);
		pin(0, 1'b0);
		pin(0, 1'b1);
		chk(16'({txoe, rxoe}), 16'h0000);
		pin(0, 1'b0);
		pin(3, 1'b1);
		chk(16'({macdr, mgdr}), 16'h000F);
		pin(3, 1'b0);
		$display("test isolate done");
		pin(1, 1'b1);
		pin(1, 1'b0);
		chk(16'(wirq), 16'h0000);
		xwr(`PXC_XREG_COMBO, 16'h0004);
		pin(1, 1'b1);
		pin(1, 1'b0);
		clks(30);
		chk(16'(wirq), 16'h0001);
		pin(2, 1'b1);
		pin(2, 1'b0);
		chk(16'(wirq), 16'h0000);
		for (int s = 0; s < 4; s++)
		begin
			xwr(`PXC_XREG_COMBO2, 16'({s[1:0], 1'b1}) << 7);
			@(posedge clk);
			wev <= 1'b1;
			@(posedge clk);
			wev <= 1'b0;
			for (k = 0; wirq !== 1'b1 && k < 8; k++)
				clks(1);
			for (k = 0; wirq === 1'b1 && k < 2000; k++)
				clks(1);
			chk(16'(k), 16'(wid[s]));
		end
		$display("test wake done");
		conclude();
	end
endmodule : tb
